//--- hdl/pcc_pkg.sv
package pcc_pkg;

  // Register byte offsets
  localparam logic [11:0] ADDR_LOAD_DEBUG = 12'h000;
  localparam logic [11:0] ADDR_MODE_CTYPE = 12'h004;
  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;

  // Writable-bit masks, reserved bits read as zero
  localparam logic [31:0] MASK_LOAD_DEBUG = 32'hC03F_003F;
  localparam logic [31:0] MASK_MODE_CTYPE = 32'h0700_0333;

  // Field positions in the load/debug control register
  localparam int BIT_TRI_DIS = 31;
  localparam int BIT_FREEZE = 30;
  localparam int LSB_IMM = 16;
  localparam int LSB_CRL = 0;
  // Field positions in the mode/counter-type register
  localparam int LSB_PAIRMODE = 24;
  localparam int LSB_DIR01 = 0;
  localparam int LSB_DIR23 = 4;
  localparam int LSB_DIR45 = 8;

  localparam int NUM_CH = 6;
  localparam int NUM_PAIR = 3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Counter direction codes
  typedef enum logic [1:0] {
    DIR_UP = 2'b00,
    DIR_DOWN = 2'b01,
    DIR_UPDOWN = 2'b10,
    DIR_RSVD = 2'b11
  } pcc_dir_t;

  // Decoded controls toward the output stage
  typedef struct packed {
    logic [NUM_CH-1:0] load_end;
    logic [NUM_CH-1:0] load_center;
    logic [NUM_CH-1:0] load_now;
    logic [NUM_PAIR-1:0] complementary;
    logic [NUM_PAIR-1:0] capture_ok;
  } pcc_ctrl_t;

endpackage

//--- hdl/pcc_top.sv
`timescale 1ns/100ps
//
// Contract
// - Debug ack with bit 0 tristates outputs
// - Bit 1 keeps outputs driven in debug
// - Freeze bit halts counters during debug
// - Debug bits writable only when unlocked
// - Period loads at end point normally
// - Compare loads at end or center
// - Immediate bit loads values on write
// - Immediate overrides window and center loads
// - Up-down center mode: period at end
// - Six per-channel immediate and center bits
// - Pair mode bit: independent or complementary
// - Direction 00 up, 01 down, 10 updown
// - Capture only in up or down
// - Direction fields at 1:0, 5:4, 9:8
module pcc_top #(
  parameter int CH = pcc_pkg::NUM_CH
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [11:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [11:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic DEBUG_ACK,
  input wire logic WRITE_PROTECT_UNLOCK,
  input wire logic [CH-1:0] WINDOW_LOAD_EN,
  output logic OUTPUT_TRISTATE,
  output logic COUNTER_FREEZE,
  output logic [CH-1:0] LOAD_AT_END,
  output logic [CH-1:0] LOAD_AT_CENTER,
  output logic [CH-1:0] LOAD_NOW,
  output logic [CH-1:0] WINDOW_LOAD_ACTIVE,
  output logic [2:0] PAIR_COMPLEMENTARY_SEL,
  output logic [1:0] PAIR01_COUNT_DIRECTION,
  output logic [1:0] PAIR23_COUNT_DIRECTION,
  output logic [1:0] PAIR45_COUNT_DIRECTION,
  output logic [2:0] CAPTURE_ALLOWED
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin and cross-domain inputs
  logic [1:0] dbg_sync_ff; // Debug ack comes from the core's debug domain
  logic [1:0] unlock_sync_ff; // Protection level from system controller

  // Two-stage synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      dbg_sync_ff <= 2'b00;
      unlock_sync_ff <= 2'b00;
    end else begin
      dbg_sync_ff <= {dbg_sync_ff[0], DEBUG_ACK};
      unlock_sync_ff <= {unlock_sync_ff[0], WRITE_PROTECT_UNLOCK};
    end
  end

  logic debug_ack_s;
  logic unlocked_s;
  assign debug_ack_s = dbg_sync_ff[1];
  assign unlocked_s = unlock_sync_ff[1];

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path
  logic aw_held_ff; // Address captured, waiting for data
  logic w_held_ff; // Data captured, waiting for address
  logic [11:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic do_write;
  logic awready_ff; // Address ready, kept equal to ~aw_held_ff & ~bvalid_ff
  logic wready_ff; // Data ready, kept equal to ~w_held_ff & ~bvalid_ff
  logic nxt_aw_held;
  logic nxt_w_held;
  logic nxt_bvalid;

  // Ready only while the slot is empty and no response is pending
  assign AWREADY = awready_ff;
  assign WREADY = wready_ff;
  // Address and data accepted in either order, commit when both present
  assign do_write = aw_held_ff & w_held_ff & ~bvalid_ff;

  // Next slot and response state, used only to register the readies
  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_w_held = w_held_ff;
    nxt_bvalid = bvalid_ff;
    if (AWVALID && awready_ff) begin
      nxt_aw_held = 1'b1;
    end else if (do_write) begin
      nxt_aw_held = 1'b0;
    end
    if (WVALID && wready_ff) begin
      nxt_w_held = 1'b1;
    end else if (do_write) begin
      nxt_w_held = 1'b0;
    end
    if (do_write) begin
      nxt_bvalid = 1'b1;
    end else if (BREADY) begin
      nxt_bvalid = 1'b0;
    end
  end

  // Registered readies; same timing as the decoded form, but the pins come from flops
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
    end else begin
      awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
      wready_ff <= ~nxt_w_held & ~nxt_bvalid;
    end
  end

  // Capture address and data channels independently
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= AWADDR;
      end else if (do_write) begin
        aw_held_ff <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_held_ff <= 1'b1;
        wdata_ff <= WDATA;
        wstrb_ff <= WSTRB;
      end else if (do_write) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= pcc_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      if (awaddr_ff[11:2] == pcc_pkg::ADDR_LOAD_DEBUG[11:2] ||
          awaddr_ff[11:2] == pcc_pkg::ADDR_MODE_CTYPE[11:2]) begin
        bresp_ff <= pcc_pkg::RESP_OKAY;
      end else begin
        bresp_ff <= pcc_pkg::RESP_SLVERR;
      end
    end else if (BREADY) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign BVALID = bvalid_ff;
  assign BRESP = bresp_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  logic [31:0] load_dbg_ff; // Load and debug control
  logic [31:0] mode_ff; // Pair mode and counter type
  logic [31:0] wmask;
  logic [31:0] nxt_load_dbg;
  logic [31:0] nxt_mode;

  // Byte-lane mask from strobes
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{wstrb_ff[b]}};
    end
  end

  // Next values; reserved bits always forced to zero
  always_comb begin
    logic [31:0] keep;
    keep = pcc_pkg::MASK_LOAD_DEBUG & wmask;
    // Debug bits are frozen while protection is locked
    if (!unlocked_s) begin
      keep[pcc_pkg::BIT_TRI_DIS] = 1'b0;
      keep[pcc_pkg::BIT_FREEZE] = 1'b0;
    end
    nxt_load_dbg = (load_dbg_ff & ~keep) | (wdata_ff & keep);
    nxt_mode = (mode_ff & ~(pcc_pkg::MASK_MODE_CTYPE & wmask)) |
               (wdata_ff & pcc_pkg::MASK_MODE_CTYPE & wmask);
  end

  // Load/debug register storage
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      load_dbg_ff <= pcc_pkg::RESET_VALUE;
    end else if (do_write && awaddr_ff[11:2] == pcc_pkg::ADDR_LOAD_DEBUG[11:2]) begin
      load_dbg_ff <= nxt_load_dbg;
    end
  end

  // Mode/counter-type register storage
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      mode_ff <= pcc_pkg::RESET_VALUE;
    end else if (do_write && awaddr_ff[11:2] == pcc_pkg::ADDR_MODE_CTYPE[11:2]) begin
      mode_ff <= nxt_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic arready_ff; // Mirrors ~rvalid_ff so the ready pin is a flop

  assign ARREADY = arready_ff;

  // Read mux; live register content shows the block's state
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= pcc_pkg::RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      rvalid_ff <= 1'b1;
      arready_ff <= 1'b0;
      if (ARADDR[11:2] == pcc_pkg::ADDR_LOAD_DEBUG[11:2]) begin
        rdata_ff <= load_dbg_ff;
        rresp_ff <= pcc_pkg::RESP_OKAY;
      end else if (ARADDR[11:2] == pcc_pkg::ADDR_MODE_CTYPE[11:2]) begin
        rdata_ff <= mode_ff;
        rresp_ff <= pcc_pkg::RESP_OKAY;
      end else begin
        // Unmapped: zero data with an error response
        rdata_ff <= 32'h0000_0000;
        rresp_ff <= pcc_pkg::RESP_SLVERR;
      end
    end else if (RREADY) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  assign RVALID = rvalid_ff;
  assign RDATA = rdata_ff;
  assign RRESP = rresp_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Decode toward the output stage
  logic [CH-1:0] imm;
  logic [CH-1:0] crl;
  logic [1:0] dir [3];
  pcc_pkg::pcc_ctrl_t nxt_ctrl;
  pcc_pkg::pcc_ctrl_t ctrl_ff;
  logic tri_ff;
  logic freeze_ff;
  logic [CH-1:0] win_ff;

  assign imm = load_dbg_ff[pcc_pkg::LSB_IMM +: CH];
  assign crl = load_dbg_ff[pcc_pkg::LSB_CRL +: CH];
  assign dir[0] = mode_ff[pcc_pkg::LSB_DIR01 +: 2];
  assign dir[1] = mode_ff[pcc_pkg::LSB_DIR23 +: 2];
  assign dir[2] = mode_ff[pcc_pkg::LSB_DIR45 +: 2];

  // Per-channel load timing; period always loads at end point when not immediate
  always_comb begin
    nxt_ctrl.load_now = imm;
    nxt_ctrl.load_end = ~imm;
    // Center point applies to compare only, and loses to immediate
    nxt_ctrl.load_center = crl & ~imm;
    for (int p = 0; p < pcc_pkg::NUM_PAIR; p++) begin
      nxt_ctrl.complementary[p] = mode_ff[pcc_pkg::LSB_PAIRMODE + p];
      // Capture supported in up and down only; updown and reserved excluded
      nxt_ctrl.capture_ok[p] = (dir[p] == pcc_pkg::DIR_UP) || (dir[p] == pcc_pkg::DIR_DOWN);
    end
  end

  // Registered load controls
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ctrl_ff <= '0;
      win_ff <= '0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      win_ff <= WINDOW_LOAD_EN & ~imm;
    end
  end

  // Debug effect on pins and counters, from synchronised ack
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      tri_ff <= 1'b0;
      freeze_ff <= 1'b0;
    end else begin
      // Tristate only with bit clear; set keeps outputs driving
      tri_ff <= debug_ack_s & ~load_dbg_ff[pcc_pkg::BIT_TRI_DIS];
      // Counters hold for the whole debug episode when the freeze bit is set
      freeze_ff <= debug_ack_s & load_dbg_ff[pcc_pkg::BIT_FREEZE];
    end
  end

  // Pair mode equality under group use is left to software
  assign OUTPUT_TRISTATE = tri_ff;
  assign COUNTER_FREEZE = freeze_ff;
  assign LOAD_AT_END = ctrl_ff.load_end;
  assign LOAD_AT_CENTER = ctrl_ff.load_center;
  assign LOAD_NOW = ctrl_ff.load_now;
  assign WINDOW_LOAD_ACTIVE = win_ff;
  assign PAIR_COMPLEMENTARY_SEL = ctrl_ff.complementary;
  assign CAPTURE_ALLOWED = ctrl_ff.capture_ok;
  assign PAIR01_COUNT_DIRECTION = mode_ff[pcc_pkg::LSB_DIR01 +: 2];
  assign PAIR23_COUNT_DIRECTION = mode_ff[pcc_pkg::LSB_DIR23 +: 2];
  assign PAIR45_COUNT_DIRECTION = mode_ff[pcc_pkg::LSB_DIR45 +: 2];

endmodule // pcc_top

//--- tb/pcc_top_sva.sv
`timescale 1ns/100ps
module pcc_top_sva #(
  parameter int CH = 6
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID,
  input wire logic [31:0] RDATA,
  input wire logic DEBUG_ACK,
  input wire logic OUTPUT_TRISTATE,
  input wire logic COUNTER_FREEZE,
  input wire logic [CH-1:0] LOAD_NOW,
  input wire logic [CH-1:0] LOAD_AT_END,
  input wire logic [CH-1:0] LOAD_AT_CENTER,
  input wire logic [1:0] PAIR01_COUNT_DIRECTION,
  input wire logic [2:0] CAPTURE_ALLOWED
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  //////////////////////////////////////////
  // Debug ack reaches the pins through a two-stage sync plus one register
  AST_TRI_ACK: assert property (OUTPUT_TRISTATE |-> $past(DEBUG_ACK, 3))
    else $error("tristate without ack");
  AST_FRZ_ACK: assert property (COUNTER_FREEZE |-> $past(DEBUG_ACK, 3))
    else $error("freeze without ack");
  AST_IMM_EXCL: assert property ((LOAD_NOW & LOAD_AT_CENTER) == '0)
    else $error("center load beside immediate");
  // Stable guard lets the decoded outputs settle after a write
  AST_END_NOW: assert property (!$past(RST) && $stable(LOAD_NOW) |-> LOAD_AT_END == ~LOAD_NOW)
    else $error("end load mismatch");
  AST_CAP01: assert property (!$past(RST) && $stable(PAIR01_COUNT_DIRECTION)
    |-> CAPTURE_ALLOWED[0] == !PAIR01_COUNT_DIRECTION[1])
    else $error("capture mismatch");
  AST_B_LAT: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
    else $error("write response late");
  AST_R_LAT: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read data late");
  AST_RSVD: assert property (RVALID |-> (RDATA & 32'h38C0_FCC0) == 32'h0000_0000)
    else $error("reserved bit read high");
  cover property (OUTPUT_TRISTATE);
  cover property (COUNTER_FREEZE);
  cover property (|LOAD_AT_CENTER);
endmodule // pcc_top_sva
bind pcc_top pcc_top_sva #(.CH(CH)) u_pcc_sva (.SYS_CLK(SYS_CLK), .RST(RST), .AWVALID(AWVALID),
  .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .RVALID(RVALID), .RDATA(RDATA), .DEBUG_ACK(DEBUG_ACK),
  .OUTPUT_TRISTATE(OUTPUT_TRISTATE), .COUNTER_FREEZE(COUNTER_FREEZE), .LOAD_NOW(LOAD_NOW),
  .LOAD_AT_END(LOAD_AT_END), .LOAD_AT_CENTER(LOAD_AT_CENTER),
  .PAIR01_COUNT_DIRECTION(PAIR01_COUNT_DIRECTION), .CAPTURE_ALLOWED(CAPTURE_ALLOWED));

//--- tb/pcc_top_tb.sv
`timescale 1ns/100ps
module pcc_top_tb;
  logic clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, dbg = 0, unl = 0;
  logic awready, wready, bvalid, arready, rvalid, tri_o, frz;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, r0 = 0, r1 = 0, d, x;
  logic [1:0] bresp, rresp, d01, d23, d45;
  logic [5:0] wl = 0, now, ctr, endl, wla;
  logic [2:0] cmp, cap;
  int fails = 0, checked = 0, cyc = 0, seed = 32'heaa4;
  always #5 clk = ~clk;
  pcc_top uut (.SYS_CLK(clk), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
    .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .DEBUG_ACK(dbg), .WRITE_PROTECT_UNLOCK(unl),
    .WINDOW_LOAD_EN(wl), .OUTPUT_TRISTATE(tri_o), .COUNTER_FREEZE(frz), .LOAD_AT_END(endl),
    .LOAD_AT_CENTER(ctr), .LOAD_NOW(now), .WINDOW_LOAD_ACTIVE(wla), .PAIR_COMPLEMENTARY_SEL(cmp),
    .PAIR01_COUNT_DIRECTION(d01), .PAIR23_COUNT_DIRECTION(d23), .PAIR45_COUNT_DIRECTION(d45),
    .CAPTURE_ALLOWED(cap));
  //////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  // Address and data are offered together and each released once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
    bit aw, w;
    aw = 1;
    w = 1;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (aw || w) begin
      @(posedge clk);
      if (aw && awready) begin
        aw = 0;
        awvalid <= 0;
      end
      if (w && wready) begin
        w = 0;
        wvalid <= 0;
      end
    end
    while (!bvalid) @(posedge clk);
    bready <= 0;
    chk("bresp", er, bresp);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge clk); while (!arready);
    arvalid <= 0;
    while (!rvalid) @(posedge clk);
    rready <= 0;
    chk("rdata", e, rdata);
    chk("rresp", er, rresp);
  endtask
  // Capture is allowed for up and down counting only
  function automatic logic [2:0] capf(input logic [31:0] r);
    return {~r[9], ~r[5], ~r[1]};
  endfunction
  task automatic give_verdict();
    if (fails == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Hang guard, generous against about 700 cycles of traffic
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      give_verdict();
    end
  end
  //////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    rd(12'h000, 0, pcc_pkg::RESP_OKAY);
    rd(12'h004, 0, pcc_pkg::RESP_OKAY);
    chk("end", 32'h0000_003F, endl);
    // First two passes write all ones, locked then unlocked
    for (int i = 0; i < 40; i++) begin
      x = $random(seed);
      d = (i < 2) ? 32'hFFFF_FFFF : $random(seed);
      unl <= (i < 2) ? i[0] : x[7];
      dbg <= x[6];
      wl <= x[5:0];
      repeat (3) @(posedge clk);
      wr(pcc_pkg::ADDR_LOAD_DEBUG, d, pcc_pkg::RESP_OKAY);
      r0 = (d & pcc_pkg::MASK_LOAD_DEBUG & 32'h3FFF_FFFF) | ((unl ? d : r0) & 32'hC000_0000);
      d = $random(seed);
      wr(pcc_pkg::ADDR_MODE_CTYPE, d, pcc_pkg::RESP_OKAY); // no group use here, pair bits may differ
      r1 = d & pcc_pkg::MASK_MODE_CTYPE;
      rd(pcc_pkg::ADDR_LOAD_DEBUG, r0, pcc_pkg::RESP_OKAY);
      rd(pcc_pkg::ADDR_MODE_CTYPE, r1, pcc_pkg::RESP_OKAY);
      chk("now", r0[21:16], now);
      chk("ctr", r0[5:0] & ~r0[21:16], ctr);
      chk("end", 6'(~r0[21:16]), endl);
      chk("win", wl & ~r0[21:16], wla);
      chk("tri", dbg & ~r0[31], tri_o);
      chk("frz", dbg & r0[30], frz);
      chk("pair", r1[26:24], cmp);
      chk("dir", {r1[9:8], r1[5:4], r1[1:0]}, {d45, d23, d01});
      chk("cap", capf(r1), cap);
    end
    wr(12'h008, 32'hFFFF_FFFF, pcc_pkg::RESP_SLVERR);
    rd(12'h008, 0, pcc_pkg::RESP_SLVERR);
    rd(pcc_pkg::ADDR_LOAD_DEBUG, r0, pcc_pkg::RESP_OKAY);
    give_verdict();
  end
endmodule // pcc_top_tb
